// >>> rtl/goc_top.sv
// Operational control register bank with serial port, rate timing and filter
`timescale 1ns/1ps
// Summary of operation
// - Period byte zero gives 2048 samples per second
// - Interval is time base times increment plus one
// - Sample period resets to 256 samples per second
// - Period byte 0x08 or more selects low power
// - Range field picks 320, 160 or 80 deg/s
// - Reduced ranges force minimum filter tap code
// - Two cascaded averages of two-power-m samples
// - Pole bit selects 330 Hz or 50 Hz
// - Signed twelve-bit offset added to rate
// - Offset-binary gain, 0x800 is unity
// - Command bit set starts, clears on completion
// - Software reset halts, restarts, reloads stored settings
// - Bits 3..0 store, latch, restore, autonull
// - Nonzero sleep byte sleeps count half-seconds
// - Data ready beats alarm beats general I/O
// - Direction bits 1,0 set lines two, one
// - Level bits drive outputs, reflect input pins
// - Upper byte sits at lower address plus one
module goc_top
#(
  parameter int MAX_RATE_CYCLES = goc_pkg::MAX_RATE_CYC,
  parameter int TB_FAST_CYCLES  = goc_pkg::TB_FAST_CYC,
  parameter int TB_SLOW_CYCLES  = goc_pkg::TB_SLOW_CYC,
  parameter int SLEEP_CYCLES    = goc_pkg::SLEEP_LSB_CYC,
  parameter int STARTUP_CYCLES  = goc_pkg::STARTUP_CYC,
  parameter int DEPTH           = goc_pkg::FILTER_DEPTH
)
(
  // Clock, reset, enable
  input  wire logic               clk,
  input  wire logic               rst_b,
  input  wire logic               ce,
  // Serial port pins
  input  wire logic               spi_sclk,
  input  wire logic               spi_cs_b,
  input  wire logic               spi_din,
  output logic                    spi_dout,
  output logic                    spi_dout_oe_b,
  // Digital lines
  input  wire logic [1:0]         dio_in,
  output logic      [1:0]         dio_out,
  output logic      [1:0]         dio_oe_b,
  // Line claims from data ready and alarm logic
  input  wire goc_pkg::goc_claim_s misc_claim,
  input  wire goc_pkg::goc_claim_s alarm_claim,
  // Rate data path
  input  wire goc_pkg::goc_rate_s  rate_in,
  output goc_pkg::goc_rate_s       rate_out,
  output logic                    sample_tick,
  // Analog and mode controls
  output logic      [2:0]         range_sel,
  output logic                    pole_330,
  output logic                    low_power,
  output logic                    sleeping,
  // Command operations
  input  wire logic [3:0]         cmd_done,
  output logic      [3:0]         cmd_busy,
  output logic                    soft_reset_busy,
  input  wire goc_pkg::goc_nv_s    nv_image
);
  import goc_pkg::*;

  localparam int DW = $clog2(DEPTH);
  localparam int SW = 16 + DW + 1;

  logic [15:0]  smpl;
  logic [15:0]  avg;
  logic [15:0]  off;
  logic [15:0]  scale;
  logic [15:0]  slp;
  logic [15:0]  gpio;
  logic [2:0]   sclk_q;
  logic [1:0]   cs_q;
  logic [1:0]   din_q;
  logic [1:0]   dio_q0;
  logic [1:0]   dio_s;
  logic [4:0]   bit_cnt;
  logic [15:0]  rx_sh;
  logic [15:0]  tx_sh;
  logic [15:0]  tx_next;
  logic [15:0]  rd_data;
  goc_byte_wr_s wr;
  logic         sclk_rise;
  logic         sclk_fall;
  logic         halt;
  logic [31:0]  base_cnt;
  logic [6:0]   incr_cnt;
  logic [31:0]  sleep_timer_ctrl;
  logic [7:0]   slp_left;
  logic [31:0]  start_cnt;
  logic         flt_clear;

  // Serial pins cross into clk through two flops each; sclk has a third for edge detection
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      sclk_q <= 3'h7;
      cs_q   <= 2'h3;
      din_q  <= 2'h0;
      dio_q0 <= 2'h0;
      dio_s  <= 2'h0;
    end
    else if (ce)
    begin
      sclk_q <= {sclk_q[1:0], spi_sclk};
      cs_q   <= {cs_q[0], spi_cs_b};
      din_q  <= {din_q[0], spi_din};
      dio_q0 <= dio_in;
      dio_s  <= dio_q0;
    end
  end

  assign sclk_rise = sclk_q[1] & ~sclk_q[2];
  assign sclk_fall = ~sclk_q[1] & sclk_q[2];

  // Frame shifter: sample on rising, shift out on falling sclk
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      bit_cnt       <= 5'h0;
      rx_sh         <= 16'h0000;
      tx_sh         <= 16'h0000;
      tx_next       <= 16'h0000;
      wr            <= '0;
      spi_dout      <= 1'b0;
      spi_dout_oe_b <= 1'b1;
    end
    else if (ce)
    begin
      wr.en         <= 1'b0;
      spi_dout_oe_b <= cs_q[1];
      spi_dout      <= tx_sh[15];
      if (cs_q[1])
      begin
        bit_cnt <= 5'h0;
        tx_sh   <= tx_next;
      end
      else if (sclk_rise)
      begin
        bit_cnt <= bit_cnt + 5'h1;
        rx_sh   <= {rx_sh[14:0], din_q[1]};
        if (bit_cnt == 5'(FRAME_BITS - 1))
        begin
          if (rx_sh[WR_FLAG_BIT - 1])
            wr <= '{1'b1, rx_sh[13:7], {rx_sh[6:0], din_q[1]}};
          else
            tx_next <= rd_data;
        end
      end
      else if (sclk_fall && bit_cnt != 5'h0)
        tx_sh <= {tx_sh[14:0], 1'b0};
    end
  end

  // Read side: lines set as inputs show the pin
  always_comb
  begin
    rd_data = 16'h0000;
    unique case ({rx_sh[13:8], 1'b0})
      ADDR_SMPL:  rd_data = smpl;
      ADDR_AVG:   rd_data = avg;
      ADDR_OFF:   rd_data = off;
      ADDR_SCALE: rd_data = scale;
      ADDR_SLP:   rd_data = slp;
      ADDR_GPIO:  rd_data = {6'h00, (gpio[9:8] & gpio[1:0]) |
                             (dio_s & ~gpio[1:0]), 6'h00, gpio[1:0]};
      default:    rd_data = 16'h0000;
    endcase
  end

  function automatic logic [2:0] tap_floor(input logic [2:0] rng,
                                           input logic [2:0] tap);
    logic [2:0] lim;
    lim = (rng == RANGE_80) ? MIN_TAP_80 :
          (rng == RANGE_160) ? MIN_TAP_160 : 3'h0;
    return (tap < lim) ? lim : tap;
  endfunction

  // Byte writes into control registers; upper byte at odd address
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      smpl  <= SMPL_RST;
      avg   <= AVG_RST;
      off   <= OFF_RST;
      scale <= SCALE_RST;
      slp   <= SLP_RST;
      gpio  <= GPIO_RST;
    end
    else if (ce)
    begin
      if (soft_reset_busy && start_cnt == 32'(STARTUP_CYCLES - 1))
      begin
        smpl  <= nv_image.smpl & SMPL_MASK;
        // Stored copy may break the floor; enforce it on reload too
        avg[15:3] <= nv_image.avg[15:3] & AVG_MASK[15:3];
        avg[2:0]  <= tap_floor(nv_image.avg[10:8], nv_image.avg[2:0]);
        off   <= nv_image.off & TRIM_MASK;
        scale <= nv_image.scale & TRIM_MASK;
      end
      else if (wr.en)
      begin
        unique case (wr.addr)
          ADDR_SMPL:      smpl[7:0]   <= wr.data;
          ADDR_OFF:       off[7:0]    <= wr.data;
          ADDR_OFF + 7'h1: off[11:8]  <= wr.data[3:0];
          ADDR_SCALE:     scale[7:0]  <= wr.data;
          ADDR_SCALE + 7'h1: scale[11:8] <= wr.data[3:0];
          ADDR_SLP:       slp[7:0]    <= wr.data;
          ADDR_GPIO:      gpio[1:0]   <= wr.data[1:0];
          ADDR_GPIO + 7'h1: gpio[9:8] <= wr.data[1:0];
          ADDR_AVG:
          begin
            avg[AVG_POLE_BIT] <= wr.data[AVG_POLE_BIT];
            avg[2:0] <= tap_floor(avg[10:8], wr.data[2:0]);
          end
          ADDR_AVG + 7'h1:
          begin
            avg[10:8] <= wr.data[2:0];
            avg[2:0]  <= tap_floor(wr.data[2:0], avg[2:0]);
          end
          default: ;
        endcase
      end
    end
  end

  // Command triggers: set wins over completion in the same cycle
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      cmd_busy        <= 4'h0;
      soft_reset_busy <= 1'b0;
      start_cnt       <= 32'h0;
    end
    else if (ce)
    begin
      cmd_busy <= (cmd_busy & ~cmd_done) |
                  ({4{wr.en && wr.addr == ADDR_CMD}} & wr.data[3:0]);
      if (wr.en && wr.addr == ADDR_CMD && wr.data[CMD_RESET_BIT])
      begin
        soft_reset_busy <= 1'b1;
        start_cnt       <= 32'h0;
      end
      else if (soft_reset_busy)
      begin
        start_cnt <= start_cnt + 32'h1;
        if (start_cnt == 32'(STARTUP_CYCLES - 1))
          soft_reset_busy <= 1'b0;
      end
    end
  end

  // Timed sleep in half-second units
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      slp_left <= 8'h00;
      sleep_timer_ctrl  <= 32'h0;
      sleeping <= 1'b0;
    end
    else if (ce)
    begin
      if (wr.en && wr.addr == ADDR_SLP && wr.data != 8'h00)
      begin
        slp_left <= wr.data;
        sleep_timer_ctrl  <= 32'h0;
        sleeping <= 1'b1;
      end
      else if (sleeping)
      begin
        sleep_timer_ctrl <= sleep_timer_ctrl + 32'h1;
        if (sleep_timer_ctrl == 32'(SLEEP_CYCLES - 1))
        begin
          sleep_timer_ctrl  <= 32'h0;
          slp_left <= slp_left - 8'h1;
          sleeping <= (slp_left != 8'h1);
        end
      end
    end
  end

  assign halt = sleeping | soft_reset_busy;

  // Sample timing
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      base_cnt    <= 32'h0;
      incr_cnt    <= 7'h0;
      sample_tick <= 1'b0;
    end
    else if (ce)
    begin
      sample_tick <= 1'b0;
      if (halt)
      begin
        base_cnt <= 32'h0;
        incr_cnt <= 7'h0;
      end
      else if (smpl[7:0] == 8'h00)
      begin
        base_cnt <= base_cnt + 32'h1;
        if (base_cnt >= 32'(MAX_RATE_CYCLES - 1))
        begin
          base_cnt    <= 32'h0;
          sample_tick <= 1'b1;
        end
      end
      else
      begin
        base_cnt <= base_cnt + 32'h1;
        if (base_cnt >= (smpl[SMPL_TB_BIT] ? 32'(TB_SLOW_CYCLES - 1)
                                           : 32'(TB_FAST_CYCLES - 1)))
        begin
          base_cnt <= 32'h0;
          incr_cnt <= incr_cnt + 7'h1;
          if (incr_cnt >= smpl[6:0])
          begin
            incr_cnt    <= 7'h0;
            sample_tick <= 1'b1;
          end
        end
      end
    end
  end

  // Mode outputs
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      range_sel <= AVG_RST[10:8];
      pole_330  <= AVG_RST[AVG_POLE_BIT];
      low_power <= 1'b0;
      flt_clear <= 1'b0;
    end
    else if (ce)
    begin
      range_sel <= avg[10:8];
      pole_330  <= avg[AVG_POLE_BIT];
      low_power <= (smpl[7:0] >= LOW_POWER_MIN);
      flt_clear <= (wr.en && (wr.addr == ADDR_AVG ||
                              wr.addr == ADDR_AVG + 7'h1))
                   || soft_reset_busy;
    end
  end

  // Two cascaded moving averages over 2**m samples
  logic signed [15:0] stg_in   [3];
  logic               stg_step [3];
  logic [DW:0]        ntaps;

  assign ntaps     = (DW + 1)'(1) << avg[2:0];
  assign stg_in[0] = rate_in.data;
  assign stg_step[0] = sample_tick;

  genvar gs;
  for (gs = 0; gs < 2; gs++)
  begin : g_stage
    logic signed [15:0]   mem [DEPTH];
    logic        [DW-1:0] wp;
    logic        [DW:0]   fill;
    logic signed [SW-1:0] sum;
    logic signed [SW-1:0] nsum;
    logic signed [15:0]   old;
    logic signed [15:0]   out_q;
    logic                 step_q;

    // Stage links are all continuous so each element has one driver
    assign stg_in[gs+1]   = out_q;
    assign stg_step[gs+1] = step_q;

    assign old  = (fill >= ntaps) ? mem[wp - ntaps[DW-1:0]] : 16'sh0000;
    assign nsum = sum + SW'(stg_in[gs]) - SW'(old);

    always_ff @(posedge clk)
    begin
      if (ce && stg_step[gs])
        mem[wp] <= stg_in[gs];
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
      if (!rst_b)
      begin
        wp              <= '0;
        fill            <= '0;
        sum             <= '0;
        out_q           <= 16'sh0000;
        step_q          <= 1'b0;
      end
      else if (ce)
      begin
        step_q <= 1'b0;
        if (flt_clear)
        begin
          wp   <= '0;
          fill <= '0;
          sum  <= '0;
        end
        else if (stg_step[gs])
        begin
          wp   <= wp + 1'b1;
          fill <= (fill >= ntaps) ? fill : fill + 1'b1;
          sum  <= nsum;
          out_q  <= 16'(nsum >>> avg[2:0]);
          step_q <= 1'b1;
        end
      end
    end
  end

  // Offset then gain trim on the filtered rate
  logic signed [16:0] with_off;
  logic signed [29:0] scaled;
  assign with_off = 17'(stg_in[2]) + 17'(signed'(off[11:0]));
  assign scaled   = 30'(with_off) * 30'(signed'({1'b0, scale[11:0]}));

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rate_out <= '0;
    else if (ce)
    begin
      rate_out.valid <= stg_step[2];
      if (stg_step[2])
        rate_out.data <= 16'(scaled >>> SCALE_SHIFT);
    end
  end

  // Line ownership per digital line
  genvar gl;
  for (gl = 0; gl < 2; gl++)
  begin : g_line
    always_ff @(posedge clk or negedge rst_b)
    begin
      if (!rst_b)
      begin
        dio_out[gl]  <= 1'b0;
        dio_oe_b[gl] <= 1'b1;
      end
      else if (ce)
      begin
        if (misc_claim.en[gl])
        begin
          dio_out[gl]  <= misc_claim.level[gl];
          dio_oe_b[gl] <= 1'b0;
        end
        else if (alarm_claim.en[gl])
        begin
          dio_out[gl]  <= alarm_claim.level[gl];
          dio_oe_b[gl] <= 1'b0;
        end
        else
        begin
          dio_out[gl]  <= gpio[GPIO_LVL_LSB + gl];
          dio_oe_b[gl] <= ~gpio[gl];
        end
      end
    end
  end

  // Checks: interval helper counts cycles between ticks
  logic [31:0] gap;
  logic        cfg_same;
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      gap      <= 32'h0;
      cfg_same <= 1'b0;
    end
    else if (ce)
    begin
      gap <= sample_tick ? 32'h1 : gap + 32'h1;
      if (wr.en || halt)
        cfg_same <= 1'b0;
      else if (sample_tick)
        cfg_same <= 1'b1;
    end
  end

  property p_max_rate;
    @(posedge clk) disable iff (!rst_b)
    sample_tick && cfg_same && ce && smpl[7:0] == 8'h00
      |-> gap == 32'(MAX_RATE_CYCLES);
  endproperty
  a_max_rate: assert property (p_max_rate) else $error("max rate gap");

  property p_period;
    @(posedge clk) disable iff (!rst_b)
    sample_tick && cfg_same && ce && smpl[7:0] != 8'h00
      |-> gap == (smpl[SMPL_TB_BIT] ? 32'(TB_SLOW_CYCLES) : 32'(TB_FAST_CYCLES))
                 * (32'(smpl[6:0]) + 32'h1);
  endproperty
  a_period: assert property (p_period) else $error("sample interval");

  property p_reset_period;
    @(posedge clk) !$past(rst_b) && rst_b |-> smpl == SMPL_RST;
  endproperty
  a_reset_period: assert property (p_reset_period) else $error("period reset");

  property p_low_power;
    @(posedge clk) disable iff (!rst_b)
    $past(ce) |-> low_power == ($past(smpl[7:0]) >= LOW_POWER_MIN);
  endproperty
  a_low_power: assert property (p_low_power) else $error("low power");

  property p_tap_floor;
    @(posedge clk) disable iff (!rst_b)
    (avg[10:8] == RANGE_160 |-> avg[2:0] >= MIN_TAP_160) and
    (avg[10:8] == RANGE_80 |-> avg[2:0] >= MIN_TAP_80);
  endproperty
  a_tap_floor: assert property (p_tap_floor) else $error("tap floor");

  sequence s_cmd_write;
    ce && wr.en && wr.addr == ADDR_CMD && wr.data[0];
  endsequence
  property p_cmd_hold;
    @(posedge clk) disable iff (!rst_b)
    s_cmd_write ##1 (!cmd_done[0] && ce) |=> cmd_busy[0];
  endproperty
  a_cmd_hold: assert property (p_cmd_hold) else $error("command lost");

  property p_quiet_halt;
    @(posedge clk) disable iff (!rst_b)
    $past(halt) && $past(ce) |-> !sample_tick;
  endproperty
  a_quiet_halt: assert property (p_quiet_halt) else $error("tick while halted");

  sequence s_sleep_write;
    ce && wr.en && wr.addr == ADDR_SLP && wr.data != 8'h00;
  endsequence
  property p_sleep;
    @(posedge clk) disable iff (!rst_b)
    s_sleep_write |=> sleeping && slp_left == $past(wr.data);
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep start");

  property p_line_prio;
    @(posedge clk) disable iff (!rst_b)
    ce && misc_claim.en[0] |=> !dio_oe_b[0] && dio_out[0] == $past(misc_claim.level[0]);
  endproperty
  a_line_prio: assert property (p_line_prio) else $error("line priority");

  property p_gpio_dir;
    @(posedge clk) disable iff (!rst_b)
    ce && !misc_claim.en[1] && !alarm_claim.en[1]
      |=> dio_oe_b[1] == !$past(gpio[1]);
  endproperty
  a_gpio_dir: assert property (p_gpio_dir) else $error("line direction");
endmodule

// >>> common/goc_pkg.sv
// Constants, register map and carrier types of the operational control bank
package goc_pkg;
  localparam int CLK_PERIOD_NS      = 20;
  localparam int MAX_RATE_PERIOD_NS = 488281;
  localparam int TB_FAST_NS         = 1953000;
  localparam int TB_SLOW_NS         = 60540000;
  localparam int SLEEP_LSB_NS       = 500000000;
  localparam int MAX_RATE_CYC       = MAX_RATE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int TB_FAST_CYC        = TB_FAST_NS / CLK_PERIOD_NS;
  localparam int TB_SLOW_CYC        = TB_SLOW_NS / CLK_PERIOD_NS;
  localparam int SLEEP_LSB_CYC      = SLEEP_LSB_NS / CLK_PERIOD_NS;
  localparam int STARTUP_CYC        = 1024;
  localparam int FILTER_DEPTH       = 128;

  localparam logic [6:0] ADDR_OFF   = 7'h14;
  localparam logic [6:0] ADDR_SCALE = 7'h16;
  localparam logic [6:0] ADDR_GPIO  = 7'h32;
  localparam logic [6:0] ADDR_SMPL  = 7'h36;
  localparam logic [6:0] ADDR_AVG   = 7'h38;
  localparam logic [6:0] ADDR_SLP   = 7'h3a;
  localparam logic [6:0] ADDR_CMD   = 7'h3e;

  localparam logic [15:0] SMPL_RST  = 16'h0001;
  localparam logic [15:0] AVG_RST   = 16'h0402;
  localparam logic [15:0] OFF_RST   = 16'h0000;
  localparam logic [15:0] SCALE_RST = 16'h0800;
  localparam logic [15:0] SLP_RST   = 16'h0000;
  localparam logic [15:0] GPIO_RST  = 16'h0000;

  localparam logic [15:0] SMPL_MASK  = 16'h00ff;
  localparam logic [15:0] AVG_MASK   = 16'h0787;
  localparam logic [15:0] TRIM_MASK  = 16'h0fff;
  localparam logic [15:0] SLP_MASK   = 16'h00ff;
  localparam logic [15:0] GPIO_MASK  = 16'h0303;

  localparam int         SMPL_TB_BIT   = 7;
  localparam int         AVG_POLE_BIT  = 7;
  localparam int         AVG_RANGE_LSB = 8;
  localparam int         CMD_RESET_BIT = 7;
  localparam int         GPIO_LVL_LSB  = 8;
  localparam int         SCALE_SHIFT   = 11;
  localparam int         NUM_OPS       = 4;
  localparam int         FRAME_BITS    = 16;
  localparam int         WR_FLAG_BIT   = 15;
  localparam logic [7:0] LOW_POWER_MIN = 8'h08;
  localparam logic [2:0] RANGE_160     = 3'h2;
  localparam logic [2:0] RANGE_80      = 3'h1;
  localparam logic [2:0] MIN_TAP_160   = 3'h2;
  localparam logic [2:0] MIN_TAP_80    = 3'h4;

  typedef struct packed {
    logic               valid;
    logic signed [15:0] data;
  } goc_rate_s;

  typedef struct packed {
    logic [1:0] en;
    logic [1:0] level;
  } goc_claim_s;

  typedef struct packed {
    logic [15:0] smpl;
    logic [15:0] avg;
    logic [15:0] off;
    logic [15:0] scale;
  } goc_nv_s;

  typedef struct packed {
    logic       en;
    logic [6:0] addr;
    logic [7:0] data;
  } goc_byte_wr_s;
endpackage

// >>> testbench/goc_host.sv
// Serial host model that sends 16-bit frames and collects returned words
`timescale 1ns/1ps
module goc_host
(
  // Serial pins
  output logic        sclk,
  output logic        cs_b,
  output logic        din,
  input  wire logic   dout,
  input  wire logic   dout_oe_b,
  // Word received in the last frame
  output logic [15:0] rx,
  output logic        rx_ok
);
  initial
  begin
    sclk  = 1'b1;
    cs_b  = 1'b1;
    din   = 1'b0;
    rx    = 16'h0000;
    rx_ok = 1'b0;
  end

  // Clock idles high; data moves on the falling edge, both sides sample on
  // the rising edge. Frame length is a whole number of bench clocks.
  task automatic frame(input logic [15:0] tx);
    #7 cs_b = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      #80 sclk = 1'b0;
      din = tx[i];
      #80 sclk = 1'b1;
      rx[i] = dout & ~dout_oe_b;
    end
    #80 cs_b = 1'b1;
    din = ~din;
    rx_ok = 1'b1;
    #93 rx_ok = 1'b0;
  endtask
endmodule

// >>> testbench/goc_top_bench.sv
// Self-checking bench for the operational control register bank
`timescale 1ns/1ps
module goc_top_bench;
  import goc_pkg::*;
  logic clk = 1'b0, rst_b = 1'b0, ce = 1'b1;
  logic sclk, cs_b, din, dout, dout_oe_b, rx_ok, tick, low_power;
  logic sleeping, pole_330, srb;
  logic slp_d = 1'b0;
  logic [15:0] rx;
  logic [1:0] dio_in = 2'b00, dio_out, dio_oe_b;
  logic [2:0] range_sel;
  logic [3:0] cmd_done = 4'h0, cmd_busy;
  goc_claim_s misc = '0, alarm = '0;
  goc_rate_s rate_in = '0, rate_out;
  goc_nv_s nv = '0;
  logic [16:0] q[$];
  logic [16:0] e;
  logic [15:0] r, o;
  int n_fail = 0, checks = 0, slp_n, rst_n, tk_n;
  int seed = 32'hb83c;
  logic [7:0] pb[5] = '{8'h00, 8'h02, 8'h07, 8'h08, 8'h81};
  int pe[5] = '{20, 30, 80, 90, 60};

  always #10 clk = ~clk;

  goc_host u_host (.sclk(sclk), .cs_b(cs_b), .din(din), .dout(dout),
    .dout_oe_b(dout_oe_b), .rx(rx), .rx_ok(rx_ok));

  goc_top #(.MAX_RATE_CYCLES(20), .TB_FAST_CYCLES(10), .TB_SLOW_CYCLES(30),
    .SLEEP_CYCLES(50), .STARTUP_CYCLES(16)) u_goc_top (.clk(clk),
    .rst_b(rst_b), .ce(ce), .spi_sclk(sclk), .spi_cs_b(cs_b),
    .spi_din(din), .spi_dout(dout), .spi_dout_oe_b(dout_oe_b),
    .dio_in(dio_in), .dio_out(dio_out), .dio_oe_b(dio_oe_b),
    .misc_claim(misc), .alarm_claim(alarm), .rate_in(rate_in),
    .rate_out(rate_out), .sample_tick(tick), .range_sel(range_sel),
    .pole_330(pole_330), .low_power(low_power), .sleeping(sleeping),
    .cmd_done(cmd_done), .cmd_busy(cmd_busy), .soft_reset_busy(srb),
    .nv_image(nv));

  task automatic chk(input string nm, input logic [15:0] x,
                     input logic [15:0] g);
    checks++;
    if (g !== x)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, x, g);
    end
  endtask

  task automatic results();
    if (n_fail == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Each frame notes what its returned word should be
  always @(posedge rx_ok)
  begin
    e = q.pop_front();
    if (e[16])
      chk("read", e[15:0], rx);
  end

  always @(posedge clk)
  begin
    slp_n <= slp_n + int'(sleeping);
    rst_n <= rst_n + int'(srb);
    // A tick launched on the edge that starts sleep is not a sleep tick
    slp_d <= sleeping;
    tk_n  <= tk_n + int'(tick & sleeping & slp_d);
  end

  task automatic xf(input logic [15:0] w, input logic c,
                    input logic [15:0] x);
    q.push_back({c, x});
    u_host.frame(w);
  endtask

  task automatic wb(input logic [6:0] a, input logic [7:0] d);
    xf({1'b1, a, d}, 1'b0, 16'h0000);
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] v);
    wb(a, v[7:0]);
    wb(a + 7'h01, v[15:8]);
  endtask

  task automatic rd(input logic [6:0] a, input logic [15:0] x);
    xf({1'b0, a, 8'h00}, 1'b0, 16'h0000);
    xf(16'h0000, 1'b1, x);
  endtask

  task automatic per(input int x);
    int k, n;
    k = 0;
    n = 0;
    for (int j = 0; j < 400 && k < 3; j++)
    begin
      @(posedge clk);
      if (k == 2)
        n++;
      if (tick === 1'b1)
        k++;
    end
    chk("period", 16'(x), 16'(n));
  endtask

  task automatic rv(input logic [15:0] x);
    for (int j = 0; j < 3000; j++)
    begin
      @(posedge clk);
      if (rate_out.valid === 1'b1 && j > 500)
        break;
    end
    chk("rate", x, rate_out.data);
  endtask

  initial
  begin
    #1ms;
    n_fail++;
    results();
  end

  initial
  begin
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    rd(ADDR_SMPL, SMPL_RST);
    per(20);
    rd(ADDR_AVG, AVG_RST);
    rd(ADDR_OFF, OFF_RST);
    rd(ADDR_SCALE, SCALE_RST);
    rd(ADDR_SLP, SLP_RST);
    rd(7'h06, 16'h0000);
    foreach (pb[i])
    begin
      wr(ADDR_SMPL, {8'h00, pb[i]});
      per(pe[i]);
      chk("low_power", 16'(pb[i] >= 8'h08), 16'(low_power));
    end
    wb(ADDR_AVG, 8'h00);
    rd(ADDR_AVG, 16'h0400);
    wb(ADDR_AVG + 7'h01, 8'h01);
    rd(ADDR_AVG, 16'h0104);
    wb(ADDR_AVG, 8'h81);
    chk("range", 16'h0001, 16'(range_sel));
    chk("pole", 16'h0001, 16'(pole_330));
    wb(ADDR_AVG + 7'h01, 8'h02);
    wb(ADDR_AVG, 8'h00);
    rd(ADDR_AVG, 16'h0202);
    chk("pole", 16'h0000, 16'(pole_330));
    for (int b = 0; b < 4; b++)
    begin
      wb(ADDR_CMD, 8'h01 << b);
      chk("busy", 16'h0001 << b, 16'(cmd_busy));
      @(posedge clk);
      cmd_done[b] <= 1'b1;
      @(posedge clk);
      cmd_done <= 4'h0;
      repeat (3) @(posedge clk);
      chk("busy", 16'h0000, 16'(cmd_busy));
    end
    rd(ADDR_CMD, 16'h0000);
    wr(ADDR_SMPL, 16'h0000);
    slp_n = 0;
    tk_n = 0;
    wb(ADDR_SLP, 8'h02);
    repeat (150) @(posedge clk);
    chk("sleep", 16'd100, 16'(slp_n));
    chk("sleep_tick", 16'h0000, 16'(tk_n));
    dio_in <= 2'($random(seed));
    wb(ADDR_GPIO + 7'h01, 8'h02);
    wb(ADDR_GPIO, 8'h02);
    chk("dio_oe_b", 16'h0001, 16'(dio_oe_b));
    chk("dio_out", 16'h0001, 16'(dio_out[1]));
    rd(ADDR_GPIO, {7'h01, dio_in[0], 8'h02});
    alarm <= '{en: 2'b10, level: 2'b00};
    repeat (3) @(posedge clk);
    chk("dio_out", 16'h0000, 16'(dio_out[1]));
    misc <= '{en: 2'b10, level: 2'b10};
    repeat (3) @(posedge clk);
    chk("dio_out", 16'h0001, 16'(dio_out[1]));
    r = 16'($random(seed)) & 16'h03ff;
    o = 16'($random(seed)) & 16'h0fff;
    rate_in <= '{valid: 1'b0, data: r};
    wb(ADDR_AVG + 7'h01, 8'h04);
    wb(ADDR_AVG, 8'h00);
    wr(ADDR_OFF, o | 16'hf000);
    rd(ADDR_OFF, o);
    rv(r + {{4{o[11]}}, o[11:0]});
    wr(ADDR_OFF, 16'h0000);
    wr(ADDR_SCALE, 16'h0400);
    rv(r >> 1);
    nv <= {32'($random(seed)), 32'($random(seed))};
    rst_n = 0;
    wb(ADDR_CMD, 8'h80);
    repeat (20) @(posedge clk);
    chk("soft_reset", 16'd16, 16'(rst_n));
    rd(ADDR_SMPL, nv.smpl & SMPL_MASK);
    rd(ADDR_OFF, nv.off & TRIM_MASK);
    results();
  end
endmodule
